// *** sacss_pkg.sv ***
package sacss_pkg;
	localparam logic [7:0] SACSS_SP_OFF = 8'h81;
	localparam logic [7:0] SACSS_AUX_OFF = 8'h8e;
	localparam logic [7:0] SACSS_MEM_OFF = 8'h96;
	localparam logic [7:0] SACSS_SPX_OFF = 8'h9e;
	localparam logic [7:0] SACSS_FUSE_OFF = 8'hf8;
	localparam logic [7:0] SACSS_STAT_OFF = 8'hf9;
	localparam logic [7:0] SACSS_SP_RST = 8'h07;
	localparam logic [7:0] SACSS_AUX_RST = 8'h00;
	localparam logic [7:0] SACSS_MEM_RST = 8'h00;
	localparam logic [7:0] SACSS_SPX_RST = 8'h00;
	localparam int SACSS_EXT_STACK_ENABLE_BIT = 4;
	localparam int SACSS_EXTERNAL_RAM_BYPASS_BIT = 1;
	localparam int SACSS_CWE_BIT = 7;
	localparam int SACSS_SIG_BIT = 6;
	localparam int SACSS_FDS_BIT = 5;
	localparam logic [7:0] SACSS_AUX_MASK = 8'h1f;
	localparam logic [7:0] SACSS_MEM_MASK = 8'he0;
	localparam logic [7:0] SACSS_SPX_MASK = 8'h0f;
	localparam logic [15:0] SACSS_FLASH_DATA_SPACE_BASE = 16'h1000;
	localparam logic [15:0] SACSS_FLASH_DATA_SPACE_LAST = 16'h2fff;
	localparam logic [15:0] SACSS_EXTRA_RAM_SPACE_LAST = 16'h0fff;
	localparam logic [15:0] SACSS_SIG_LAST = 16'h01ff;
	typedef enum logic [2:0] {
		SACSS_SP_INTERNAL_INDIRECT_RAM = 3'b000,
		SACSS_SP_EXTRA_RAM_SPACE = 3'b001,
		SACSS_SP_FLASH_DATA_SPACE = 3'b010,
		SACSS_SP_EXTERNAL_DATA_SPACE = 3'b011,
		SACSS_SP_CODE = 3'b100,
		SACSS_SP_SIG = 3'b101
	} sacss_space_t;
	typedef enum logic [1:0] {
		SACSS_ST_RUN = 2'b00,
		SACSS_ST_STALL = 2'b01,
		SACSS_ST_IAP = 2'b10
	} sacss_state_t;
endpackage

// *** sacss_top.sv ***
// Functional notes
// - Without extended stack, stack sits in 256-byte internal RAM via 8-bit pointer.
// - Extended stack enable moves the stack into extra RAM, up to 4KB.
// - Extended stack address is upper pointer low nibble over pointer byte.
// - Each stack wraps only within its own space, never into the other.
// - Upper stack pointer is ignored while extended stack is disabled.
// - Extended stack adds one extra cycle per stack access made, none if a code write starts in the same cycle.
// - Extended stack stays in internal extra RAM even with external bypass set.
// - CPU idles during code write and resumes once code write done is signalled.
// - Code write enable needs the fuse; fuse off forces it to zero.
// - Code write enable without signature select sends data moves to code space.
// - Code write with signature select sends data and code moves to signature array.
// - Otherwise data moves hit extra RAM, flash data or external data space; code reads follow signature select.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
module sacss_top
	import sacss_pkg::*;
#(
	parameter int STK_ACC_MAX = 2
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_fuse_code_write,
	input wire logic i_stk_req,
	input wire logic [1:0] i_stk_nacc,
	input wire logic i_stk_push,
	output logic o_stk_stall,
	output logic [11:0] o_stk_addr,
	output sacss_pkg::sacss_space_t o_stk_space,
	input wire logic i_xmove,
	input wire logic i_cmove,
	input wire logic [15:0] i_dptr,
	output sacss_pkg::sacss_space_t o_move_space,
	output logic [15:0] o_move_addr,
	input wire logic i_xmove_wr,
	input wire logic i_code_wr_done,
	output logic o_cpu_idle
);
	import sacss_pkg::*;

	if (STK_ACC_MAX != 2) begin : g_bad_acc
		$error("STK_ACC_MAX must be 2");
	end

	logic [7:0] sp_r, sp_nxt;
	logic [7:0] aux_r;
	logic [7:0] mem_r, mem_nxt;
	logic [7:0] spx_r, spx_nxt;
	logic [1:0] pen_r;
	logic [2:0] fuse_sync_r;
	logic fuse_ok_r;
	sacss_state_t st_r, st_nxt;

	wire sel_sp = (i_addr == SACSS_SP_OFF);
	wire sel_aux = (i_addr == SACSS_AUX_OFF);
	wire sel_mem = (i_addr == SACSS_MEM_OFF);
	wire sel_spx = (i_addr == SACSS_SPX_OFF);
	wire sel_fuse = (i_addr == SACSS_FUSE_OFF);
	wire sel_stat = (i_addr == SACSS_STAT_OFF);
	wire ext_stack_enable = aux_r[SACSS_EXT_STACK_ENABLE_BIT];
	wire external_ram_bypass = aux_r[SACSS_EXTERNAL_RAM_BYPASS_BIT];
	wire cwe = mem_r[SACSS_CWE_BIT];
	wire signature_select = mem_r[SACSS_SIG_BIT];
	wire fds = mem_r[SACSS_FDS_BIT];
	wire stk_go = i_stk_req && (st_r == SACSS_ST_RUN);

	wire [7:0] sp_step = i_stk_push ? 8'h01 : 8'hff;
	wire [11:0] xptr = {spx_r[3:0], sp_r};
	wire [11:0] xptr_step = xptr + (i_stk_push ? 12'h001 : 12'hfff);

	assign o_stk_addr = ext_stack_enable ? xptr : {4'h0, sp_r};
	assign o_stk_space = ext_stack_enable ? SACSS_SP_EXTRA_RAM_SPACE : SACSS_SP_INTERNAL_INDIRECT_RAM;

	always_comb begin
		sp_nxt = sp_r;
		spx_nxt = spx_r;
		if (i_wr && sel_sp) begin
			sp_nxt = i_wdata;
		end else if (stk_go) begin
			if (ext_stack_enable) begin
				sp_nxt = xptr_step[7:0];
			end else begin
				sp_nxt = sp_r + sp_step;
			end
		end
		if (i_wr && sel_spx) begin
			spx_nxt = i_wdata & SACSS_SPX_MASK;
		end else if (stk_go && ext_stack_enable) begin
			spx_nxt = {4'h0, xptr_step[11:8]};
		end
	end

	always_comb begin
		o_move_addr = i_dptr;
		if (i_cmove) begin
			o_move_space = signature_select ? SACSS_SP_SIG : SACSS_SP_CODE;
		end else if (cwe) begin
			o_move_space = signature_select ? SACSS_SP_SIG : SACSS_SP_CODE;
		end else if (external_ram_bypass) begin
			o_move_space = SACSS_SP_EXTERNAL_DATA_SPACE;
		end else if (!fds && i_dptr <= SACSS_EXTRA_RAM_SPACE_LAST) begin
			o_move_space = SACSS_SP_EXTRA_RAM_SPACE;
		end else if (fds && i_dptr >= SACSS_FLASH_DATA_SPACE_BASE && i_dptr <= SACSS_FLASH_DATA_SPACE_LAST) begin
			o_move_space = SACSS_SP_FLASH_DATA_SPACE;
		end else begin
			o_move_space = SACSS_SP_EXTERNAL_DATA_SPACE;
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			SACSS_ST_RUN: begin
				if (i_xmove && i_xmove_wr && cwe) begin
					st_nxt = SACSS_ST_IAP;
				end else if (stk_go && ext_stack_enable && i_stk_nacc != 2'd0) begin
					st_nxt = SACSS_ST_STALL;
				end
			end
			SACSS_ST_STALL: begin
				if (pen_r <= 2'd1) begin
					st_nxt = SACSS_ST_RUN;
				end
			end
			SACSS_ST_IAP: begin
				if (i_code_wr_done) begin
					st_nxt = SACSS_ST_RUN;
				end
			end
			default: begin
				st_nxt = SACSS_ST_RUN;
			end
		endcase
	end

	assign o_stk_stall = (st_r == SACSS_ST_STALL);
	assign o_cpu_idle = (st_r == SACSS_ST_IAP);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r <= SACSS_ST_RUN;
			pen_r <= 2'd0;
		end else begin
			st_r <= st_nxt;
			if (st_r == SACSS_ST_RUN) begin
				pen_r <= i_stk_nacc;
			end else if (pen_r != 2'd0) begin
				pen_r <= pen_r - 2'd1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sp_r <= SACSS_SP_RST;
			spx_r <= SACSS_SPX_RST;
			aux_r <= SACSS_AUX_RST;
		end else begin
			sp_r <= sp_nxt;
			spx_r <= spx_nxt;
			if (i_wr && sel_aux) begin
				aux_r <= i_wdata & SACSS_AUX_MASK;
			end
		end
	end

	// fuse synchroniser
	// The fuse level is a pin, so a change only counts once the last two stages agree.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			fuse_sync_r <= 3'h0;
			fuse_ok_r <= 1'b0;
		end else begin
			fuse_sync_r <= {fuse_sync_r[1:0], i_fuse_code_write};
			if (fuse_sync_r[1] == fuse_sync_r[2]) begin
				fuse_ok_r <= fuse_sync_r[2];
			end
		end
	end

	// fuse gate
	// The gate clears the enable in every cycle the fuse is off, so neither a write nor an old value slips past it.
	always_comb begin
		mem_nxt = mem_r;
		if (i_wr && sel_mem) begin
			mem_nxt = i_wdata & SACSS_MEM_MASK;
		end
		if (!fuse_ok_r) begin
			mem_nxt[SACSS_CWE_BIT] = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mem_r <= SACSS_MEM_RST;
		end else begin
			mem_r <= mem_nxt;
		end
	end

	wire [7:0] rd_mux = sel_sp ? sp_r :
		sel_aux ? aux_r :
		sel_mem ? mem_r :
		sel_spx ? spx_r :
		sel_fuse ? {7'h00, fuse_ok_r} :
		sel_stat ? {5'h00, o_cpu_idle, o_stk_stall, ext_stack_enable} : 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rd_mux;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Checks on the fuse gate, the stack, the move decoder and code-write sequencing follow.

	AST_CWE_FUSE: assert property (@(posedge i_clk) disable iff (i_srst)
		!fuse_ok_r |=> !mem_r[SACSS_CWE_BIT])
		else $error("code write enable set without fuse");

	AST_FUSE_SYNC: assert property (@(posedge i_clk) disable iff (i_srst)
		fuse_ok_r != $past(fuse_ok_r) |-> $past(fuse_sync_r[1]) == $past(fuse_sync_r[2]))
		else $error("fuse level taken before stages agreed");

	AST_STK_INT: assert property (@(posedge i_clk) disable iff (i_srst)
		!ext_stack_enable |-> o_stk_addr[11:8] == 4'h0 && o_stk_space == SACSS_SP_INTERNAL_INDIRECT_RAM)
		else $error("internal stack address wrong");

	AST_SP_INT: assert property (@(posedge i_clk) disable iff (i_srst)
		stk_go && !ext_stack_enable && !i_wr |=> sp_r == 8'($past(sp_r) + ($past(i_stk_push) ? 8'h01 : 8'hff)))
		else $error("internal stack step wrong");

	AST_STK_EXT: assert property (@(posedge i_clk) disable iff (i_srst)
		ext_stack_enable |-> o_stk_space == SACSS_SP_EXTRA_RAM_SPACE)
		else $error("extended stack not in extra ram");

	AST_XPTR: assert property (@(posedge i_clk) disable iff (i_srst)
		ext_stack_enable |-> o_stk_addr == {spx_r[3:0], sp_r})
		else $error("extended pointer mismatch");

	AST_SPX_MASK: assert property (@(posedge i_clk) disable iff (i_srst)
		spx_r[7:4] == 4'h0)
		else $error("upper pointer high nibble set");

	AST_WRAP: assert property (@(posedge i_clk) disable iff (i_srst)
		stk_go && !ext_stack_enable && !i_wr && i_stk_push && sp_r == 8'hff |=> sp_r == 8'h00 && $stable(spx_r))
		else $error("internal stack wrapped outward");

	AST_EXT_STACK_ENABLE_STEP: assert property (@(posedge i_clk) disable iff (i_srst)
		stk_go && ext_stack_enable && !i_wr |=> {spx_r[3:0], sp_r} == 12'($past(xptr) + ($past(i_stk_push) ? 12'h001 : 12'hfff)))
		else $error("extended stack step wrong");

	AST_SPX_IGN: assert property (@(posedge i_clk) disable iff (i_srst)
		!ext_stack_enable && !(i_wr && sel_spx) |=> $stable(spx_r))
		else $error("upper pointer touched while disabled");

	AST_PEN: assert property (@(posedge i_clk) disable iff (i_srst)
		stk_go && ext_stack_enable && i_stk_nacc == 2'd2 && !(i_xmove && i_xmove_wr && cwe) |=> o_stk_stall [*2] ##1 !o_stk_stall)
		else $error("stack penalty length wrong");

	AST_PEN_ONE: assert property (@(posedge i_clk) disable iff (i_srst)
		stk_go && ext_stack_enable && i_stk_nacc == 2'd1 && !(i_xmove && i_xmove_wr && cwe) |=> o_stk_stall ##1 !o_stk_stall)
		else $error("single stack penalty wrong");

	AST_NO_PEN_INT: assert property (@(posedge i_clk) disable iff (i_srst)
		stk_go && !ext_stack_enable |=> !o_stk_stall)
		else $error("internal stack stalled");

	AST_EXTERNAL_RAM_BYPASS: assert property (@(posedge i_clk) disable iff (i_srst)
		ext_stack_enable && external_ram_bypass |-> o_stk_space != SACSS_SP_EXTERNAL_DATA_SPACE)
		else $error("stack went external");

	AST_IAP: assert property (@(posedge i_clk) disable iff (i_srst)
		st_r == SACSS_ST_RUN && i_xmove && i_xmove_wr && cwe |=> o_cpu_idle)
		else $error("cpu not idled for code write");

	AST_IDLE_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
		o_cpu_idle && !i_code_wr_done |=> o_cpu_idle)
		else $error("cpu released before code write done");

	AST_IDLE_END: assert property (@(posedge i_clk) disable iff (i_srst)
		o_cpu_idle && i_code_wr_done |=> !o_cpu_idle)
		else $error("cpu not released after code write");

	AST_IDLE_SP: assert property (@(posedge i_clk) disable iff (i_srst)
		o_cpu_idle && !i_wr |=> $stable(sp_r))
		else $error("stack moved while cpu idle");

	AST_IDLE_NOSTALL: assert property (@(posedge i_clk) disable iff (i_srst)
		o_cpu_idle |-> !o_stk_stall)
		else $error("stall and idle together");

	AST_CODE: assert property (@(posedge i_clk) disable iff (i_srst)
		i_xmove && !i_cmove && cwe && !signature_select |-> o_move_space == SACSS_SP_CODE)
		else $error("data move not to code");

	AST_MOVE_ADDR: assert property (@(posedge i_clk) disable iff (i_srst)
		i_xmove || i_cmove |-> o_move_addr == i_dptr)
		else $error("move address altered");

	AST_SIG: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_xmove || i_cmove) && cwe && signature_select |-> o_move_space == SACSS_SP_SIG)
		else $error("move not to signature");

	AST_FLASH_DATA_SPACE: assert property (@(posedge i_clk) disable iff (i_srst)
		i_xmove && !i_cmove && !cwe && !external_ram_bypass && fds && i_dptr == 16'h1000 |-> o_move_space == SACSS_SP_FLASH_DATA_SPACE)
		else $error("flash data not selected");

	AST_EXTRA_RAM_SPACE: assert property (@(posedge i_clk) disable iff (i_srst)
		i_xmove && !i_cmove && !cwe && !external_ram_bypass && !fds && i_dptr <= SACSS_EXTRA_RAM_SPACE_LAST |-> o_move_space == SACSS_SP_EXTRA_RAM_SPACE)
		else $error("extra ram not selected");

	AST_CMOVE: assert property (@(posedge i_clk) disable iff (i_srst)
		i_cmove && !signature_select |-> o_move_space == SACSS_SP_CODE)
		else $error("code move not to code");

	AST_BYPASS: assert property (@(posedge i_clk) disable iff (i_srst)
		i_xmove && !i_cmove && !cwe && external_ram_bypass |-> o_move_space == SACSS_SP_EXTERNAL_DATA_SPACE)
		else $error("bypassed move not external");
endmodule
`default_nettype wire

// *** sacss_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sacss_cpu_model (
	input wire logic i_clk,
	input wire logic i_idle,
	input wire logic i_stall,
	input wire logic i_want,
	input wire logic [3:0] i_lat,
	output logic o_req,
	output logic o_done
);
	logic [3:0] cnt_r;
	// The core holds back stack steps while it is stalled or idle.
	assign o_req = i_want & ~i_stall & ~i_idle;
	// The memory write ends a chosen number of idle cycles after it began.
	assign o_done = i_idle & (cnt_r == i_lat);
	always_ff @(posedge i_clk) begin
		cnt_r <= i_idle ? cnt_r + 4'h1 : 4'h0;
	end
endmodule
`default_nettype wire

// *** sacss_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sacss_top_tb;
	import sacss_pkg::*;
	logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, fuse = 1'h1, want = 1'h0, push = 1'h1;
	logic xm = 1'h0, cm = 1'h0, xwr = 1'h0, stall, idle, req, done;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat, d;
	logic [1:0] nacc = 2'h1;
	logic [15:0] dptr = 16'h0000;
	logic [15:0] maddr;
	logic [3:0] lat = 4'h5;
	logic [11:0] saddr;
	sacss_space_t sspace, mspace;
	int n_mismatch = 0, n_checks = 0, k;
	sacss_top u_sacss_top (.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdat), .i_fuse_code_write(fuse), .i_stk_req(req), .i_stk_nacc(nacc), .i_stk_push(push),
		.o_stk_stall(stall), .o_stk_addr(saddr), .o_stk_space(sspace), .i_xmove(xm), .i_cmove(cm),
		.i_dptr(dptr), .o_move_space(mspace), .o_move_addr(maddr), .i_xmove_wr(xwr), .i_code_wr_done(done),
		.o_cpu_idle(idle));
	sacss_cpu_model u_sacss_cpu_model (.i_clk(clk), .i_idle(idle), .i_stall(stall), .i_want(want),
		.i_lat(lat), .o_req(req), .o_done(done));
	function automatic sacss_space_t exp_sp(logic [2:0] m, logic c);
		if (m[2] || c)
			return m[1] ? SACSS_SP_SIG : SACSS_SP_CODE;
		return m[0] ? SACSS_SP_FLASH_DATA_SPACE : SACSS_SP_EXTRA_RAM_SPACE;
	endfunction
	task automatic chk(string n, logic [15:0] ex, logic [15:0] got);
		n_checks++;
		if (got !== ex) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", n, ex, got);
		end
	endtask
	task automatic wreg(logic [7:0] a, logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask
	task automatic cr(logic [7:0] a, logic [7:0] ex);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk("register", ex, rdat);
	endtask
	task automatic step(logic p, logic [1:0] n, output int s);
		@(posedge clk);
		want <= 1'h1;
		push <= p;
		nacc <= n;
		@(posedge clk);
		want <= 1'h0;
		s = 0;
		repeat (4) begin
			#1 if (stall === 1'h1) s++;
			@(posedge clk);
		end
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		#(5000 * 50);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		k = $urandom(32'h1223c03d);
		repeat (8) @(posedge clk);
		srst <= 1'h0;
		cr(SACSS_SP_OFF, 8'h07);
		cr(SACSS_AUX_OFF, 8'h00);
		cr(SACSS_MEM_OFF, 8'h00);
		cr(SACSS_SPX_OFF, 8'h00);
		cr(8'h50, 8'h00);
		wreg(SACSS_SPX_OFF, 8'hfa);
		cr(SACSS_SPX_OFF, 8'h0a);
		wreg(SACSS_SP_OFF, 8'hff);
		step(1'h1, 2'h2, k);
		chk("internal_indirect_ram stall", 16'h0, k[15:0]);
		chk("internal_indirect_ram wrap", 16'h000, saddr);
		chk("internal_indirect_ram space", SACSS_SP_INTERNAL_INDIRECT_RAM, sspace);
		$display("test internal stack end");
		wreg(SACSS_SP_OFF, 8'hff);
		wreg(SACSS_AUX_OFF, 8'h12);
		chk("ext_stack_enable addr", 16'h0aff, saddr);
		chk("ext_stack_enable space", SACSS_SP_EXTRA_RAM_SPACE, sspace);
		cr(SACSS_STAT_OFF, 8'h01);
		step(1'h1, 2'h2, k);
		chk("ext_stack_enable stall", 16'h2, k[15:0]);
		chk("ext_stack_enable carry", 16'h0b00, saddr);
		wreg(SACSS_SPX_OFF, 8'h0f);
		wreg(SACSS_SP_OFF, 8'hff);
		step(1'h1, 2'h1, k);
		chk("ext_stack_enable stall one", 16'h1, k[15:0]);
		chk("ext_stack_enable wrap", 16'h000, saddr);
		step(1'h0, 2'h1, k);
		chk("ext_stack_enable pop", 16'h0fff, saddr);
		wreg(SACSS_AUX_OFF, 8'h00);
		$display("test extended stack end");
		@(posedge clk);
		fuse <= 1'h0;
		repeat (5) @(posedge clk);
		wreg(SACSS_MEM_OFF, 8'he0);
		cr(SACSS_MEM_OFF, 8'h60);
		@(posedge clk);
		fuse <= 1'h1;
		repeat (5) @(posedge clk);
		wreg(SACSS_MEM_OFF, 8'h80);
		cr(SACSS_MEM_OFF, 8'h80);
		@(posedge clk);
		fuse <= 1'h0;
		repeat (5) @(posedge clk);
		cr(SACSS_MEM_OFF, 8'h00);
		@(posedge clk);
		fuse <= 1'h1;
		repeat (5) @(posedge clk);
		cr(SACSS_FUSE_OFF, 8'h01);
		$display("test fuse end");
		for (int m = 0; m < 16; m++) begin
			wreg(SACSS_MEM_OFF, {m[2:0], 5'h00});
			@(posedge clk);
			xm <= ~m[3];
			cm <= m[3];
			dptr <= (m[0] && !m[2] && !m[3]) ? 16'h1000 + 16'($urandom % 8192) : 16'($urandom % 512);
			#1 chk("move space", exp_sp(m[2:0], m[3]), mspace);
			chk("move addr", dptr, maddr);
		end
		$display("test moves end");
		wreg(SACSS_MEM_OFF, 8'h80);
		@(posedge clk);
		xm <= 1'h1;
		cm <= 1'h0;
		xwr <= 1'h1;
		@(posedge clk);
		xm <= 1'h0;
		xwr <= 1'h0;
		#1 chk("idle start", 16'h1, idle);
		k = 0;
		while (idle === 1'h1 && k < 30) begin
			@(posedge clk);
			#1 k++;
		end
		chk("idle length", 16'h6, k[15:0]);
		$display("test code write end");
		tally_and_finish();
	end
endmodule
`default_nettype wire
